// [core/ppsc_pkg.sv]
// Package for the process-port and sync/latch configuration block.
// Assumes an 8-bit register port with byte offsets as the register index.
package ppsc_pkg;
	localparam logic [11:0] ADDR_HOST_PORT_CFG = 12'h150;
	localparam logic [11:0] ADDR_SYNC_LATCH_CFG = 12'h151;
	localparam logic [11:0] ADDR_IFACE_CTRL = 12'h140;
	localparam logic [11:0] ADDR_EVENT_REQ = 12'h220;
	localparam logic [7:0] RST_HOST_PORT_CFG = 8'h00;
	localparam logic [7:0] RST_SYNC_LATCH_CFG = 8'h00;
	localparam logic [7:0] RST_IFACE_CTRL = 8'h00;
	localparam logic [7:0] MODE_DIGITAL_IO = 8'h04;
	localparam logic [7:0] MODE_HBUS_FIRST = 8'h88;
	localparam logic [7:0] MODE_HBUS_LAST = 8'h8d;
	localparam logic [1:0] OSEL_END_FRAME = 2'h0;
	localparam logic [1:0] OSEL_FIRST_SYNC = 2'h2;
	localparam logic [1:0] OSEL_SECOND_SYNC = 2'h3;
	localparam logic [1:0] ISEL_START_FRAME = 2'h0;
	localparam logic [1:0] ISEL_LATCH_EDGE = 2'h1;
	localparam logic [1:0] ISEL_FIRST_SYNC = 2'h2;
	localparam logic [1:0] ISEL_SECOND_SYNC = 2'h3;
	localparam logic [1:0] DRV_PP_LOW = 2'h0;
	localparam logic [1:0] DRV_OD_LOW = 2'h1;
	localparam logic [1:0] DRV_PP_HIGH = 2'h2;
	localparam logic [1:0] DRV_OS_HIGH = 2'h3;
	localparam int EVREQ_FIRST_SYNC_BIT = 2;
	localparam int EVREQ_SECOND_SYNC_BIT = 3;

	typedef struct packed {
		logic [1:0] out_sel;
		logic [1:0] in_sel;
		logic       wd_deferred;
		logic       bidir;
		logic       valid_is_wd;
		logic       valid_low;
	} ppsc_dio_cfg_t;

	typedef struct packed {
		logic       ale_cs_qual;
		logic       dir_enable;
		logic       cs_high;
		logic       rd_high;
		logic       wr_high;
		logic       ale_high;
		logic [1:0] reserved;
	} ppsc_hbus_cfg_t;

	typedef struct packed {
		logic       second_map;
		logic       second_is_sync;
		logic [1:0] second_drv;
		logic       first_map;
		logic       first_is_sync;
		logic [1:0] first_drv;
	} ppsc_sync_cfg_t;

	typedef struct packed {
		logic out;
		logic oe_n;
	} ppsc_pin_t;
endpackage

// [core/ppsc_sync_pin.sv]
// Driver for one sync output pin with selectable drive style.
// Assumes the pad combines out and oe_n; oe_n low means driving.
`timescale 1ns/1ps
`default_nettype none
module ppsc_sync_pin (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 enable_i,
	input  wire logic [1:0]           drv_i,
	input  wire logic                 pulse_i,
	output var  ppsc_pkg::ppsc_pin_t  pin_o
);
	typedef struct packed {
		ppsc_pkg::ppsc_pin_t pin;
	} ppsc_pin_state_t;

	ppsc_pin_state_t state;
	ppsc_pin_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.pin.out = 1'b0;
		next_state.pin.oe_n = 1'b1;
		if (enable_i) begin
			unique case (drv_i)
				ppsc_pkg::DRV_PP_LOW: begin
					next_state.pin.out = ~pulse_i;
					next_state.pin.oe_n = 1'b0;
				end
				ppsc_pkg::DRV_OD_LOW: begin
					next_state.pin.out = 1'b0;
					next_state.pin.oe_n = ~pulse_i;
				end
				ppsc_pkg::DRV_PP_HIGH: begin
					next_state.pin.out = pulse_i;
					next_state.pin.oe_n = 1'b0;
				end
				ppsc_pkg::DRV_OS_HIGH: begin
					next_state.pin.out = 1'b1;
					next_state.pin.oe_n = ~pulse_i;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state <= '{pin: '{out: 1'b0, oe_n: 1'b1}};
		end else begin
			state <= next_state;
		end
	end

	assign pin_o = state.pin;
endmodule
`default_nettype wire

// [core/ppsc_addr_latch.sv]
// Address latch for the host bus port, polarity and select qualified.
// Assumes strobe and chip select are synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module ppsc_addr_latch #(
	parameter int ADDR_W = 16
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ale_high_pol_i,
	input  wire logic              cs_qual_i,
	input  wire logic              cs_active_i,
	input  wire logic              strobe_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	output var  logic [ADDR_W-1:0] addr_o
);
	typedef struct packed {
		logic              strobe_q;
		logic [ADDR_W-1:0] addr;
	} ppsc_ale_state_t;

	ppsc_ale_state_t state;
	ppsc_ale_state_t next_state;
	logic            active;

	always_comb begin
		next_state = state;
		active = ale_high_pol_i ? strobe_i : ~strobe_i;
		next_state.strobe_q = active;
		// End of the active strobe saves the address in both senses
		if (state.strobe_q && !active && (!cs_qual_i || cs_active_i)) begin
			next_state.addr = addr_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign addr_o = state.addr;
endmodule
`default_nettype wire

// [core/ppsc_top.sv]
// Process-port and sync/latch configuration block with its steered logic.
// Assumes one 40 MHz clock, synchronous pins and a loader for defaults.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Host port config bits mean different things in digital and host-bus modes.
// - Digital mode bits 7:6 pick output sample: frame end, sync one, sync two.
// - Digital bits 5:4 pick input sample: frame start, latch rise, sync events.
// - Bit 3: watchdog expiry resets outputs now, or at next output event.
// - Bit 2 chooses per-pin direction or bidirectional mode, which leaves all pins undriven.
// - Bit 1: valid strobe shows output events or watchdog trigger.
// - Host-bus bit 7 makes address latching depend on chip select.
// - Host-bus bit 6 picks separate strobes or direction plus enable.
// - Host-bus bit 5 sets chip select polarity.
// - Bit 4 sets read polarity, or direction sense in enable style.
// - Bit 3 sets write polarity, or enable polarity in enable style.
// - Bit 2 sets address strobe polarity and its capture edge.
// - Sync map bit 7 copies second sync into event request bit 3.
// - Sync map bit 3 copies first sync into event request bit 2.
// - Two-bit driver fields set push-pull, open drain or open source.
// - All fields reset to zero, or take loaded defaults.
// - Interface code 04h is digital, 88h to 8Dh host-bus.
module ppsc_top #(
	parameter int IO_W   = 16,
	parameter int ADDR_W = 16
) (
	input  wire logic               mclk_i,
	input  wire logic               rst_n_i,
	input  wire logic               load_i,
	input  wire logic [7:0]         load_iface_ctrl_i,
	input  wire logic [7:0]         load_host_port_cfg_i,
	input  wire logic [7:0]         load_sync_latch_cfg_i,
	input  wire logic [11:0]        reg_addr_i,
	input  wire logic [7:0]         reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output var  logic [7:0]         reg_rdata_o,
	input  wire logic               frame_start_i,
	input  wire logic               frame_end_i,
	input  wire logic               first_sync_pulse_i,
	input  wire logic               second_sync_pulse_i,
	input  wire logic               first_latch_input_i,
	input  wire logic               second_latch_input_i,
	input  wire logic               latch_in_i,
	input  wire logic               watchdog_trigger_pulse_i,
	input  wire logic               watchdog_expired_i,
	input  wire logic [IO_W-1:0]    out_data_i,
	input  wire logic [IO_W-1:0]    pin_dir_out_i,
	input  wire logic [IO_W-1:0]    io_pin_i,
	output var  logic [IO_W-1:0]    io_pin_o,
	output var  logic [IO_W-1:0]    io_pin_oe_n_o,
	output var  logic [IO_W-1:0]    in_data_o,
	output var  logic               output_valid_strobe_o,
	output var  logic               first_sync_out_o,
	output var  logic               first_sync_oe_n_o,
	output var  logic               second_sync_out_o,
	output var  logic               second_sync_oe_n_o,
	output var  logic [1:0]         first_latch_o,
	output var  logic [1:0]         event_request_o,
	output var  logic               digital_mode_o,
	output var  logic               host_bus_mode_o,
	input  wire logic               hb_cs_i,
	input  wire logic               hb_rd_i,
	input  wire logic               hb_wr_i,
	input  wire logic               addr_latch_strobe_high_i,
	input  wire logic               addr_latch_strobe_low_i,
	input  wire logic [ADDR_W-1:0]  hb_addr_i,
	output var  logic               hb_read_o,
	output var  logic               hb_write_o,
	output var  logic [ADDR_W-1:0]  hb_addr_hi_o,
	output var  logic [ADDR_W-1:0]  hb_addr_lo_o
);
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0]      iface_ctrl;
		logic [7:0]      host_cfg;
		ppsc_pkg::ppsc_sync_cfg_t sync_cfg;
		logic [7:0]      rdata;
		logic            latch_q;
		logic            wd_pending;
		logic [IO_W-1:0] out_reg;
		logic [IO_W-1:0] in_reg;
		logic            valid;
		logic [1:0]      evreq;
		logic            dmode;
		logic            hmode;
		logic            hb_read;
		logic            hb_write;
		logic [1:0]      latch_seen;
		logic [IO_W-1:0] oe_n;
	} ppsc_state_t;

	ppsc_state_t              state;
	ppsc_state_t              next_state;
	ppsc_pkg::ppsc_dio_cfg_t  dio;
	ppsc_pkg::ppsc_hbus_cfg_t hbc;
	ppsc_pkg::ppsc_pin_t      first_pin;
	ppsc_pkg::ppsc_pin_t      second_pin;
	logic                     out_event;
	logic                     in_event;
	logic                     cs_active;
	logic                     rd_act;
	logic                     wr_act;

	function automatic logic is_host_bus(input logic [7:0] code);
		return (code >= ppsc_pkg::MODE_HBUS_FIRST) && (code <= ppsc_pkg::MODE_HBUS_LAST);
	endfunction

	assign dio = ppsc_pkg::ppsc_dio_cfg_t'(state.host_cfg);
	assign hbc = ppsc_pkg::ppsc_hbus_cfg_t'(state.host_cfg);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		out_event = 1'b0;
		in_event = 1'b0;
		cs_active = 1'b0;
		rd_act = 1'b0;
		wr_act = 1'b0;
		// Register file is loaded only by the defaults loader
		if (load_i) begin
			next_state.iface_ctrl = load_iface_ctrl_i;
			next_state.host_cfg = load_host_port_cfg_i;
			next_state.sync_cfg = ppsc_pkg::ppsc_sync_cfg_t'(load_sync_latch_cfg_i);
		end
		next_state.rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ppsc_pkg::ADDR_IFACE_CTRL: next_state.rdata = state.iface_ctrl;
				ppsc_pkg::ADDR_HOST_PORT_CFG: next_state.rdata = state.host_cfg;
				ppsc_pkg::ADDR_SYNC_LATCH_CFG: next_state.rdata = state.sync_cfg;
				ppsc_pkg::ADDR_EVENT_REQ: next_state.rdata = {4'h0, state.evreq, 2'h0};
				default: next_state.rdata = 8'h00;
			endcase
		end
		next_state.dmode = (state.iface_ctrl == ppsc_pkg::MODE_DIGITAL_IO);
		next_state.hmode = is_host_bus(state.iface_ctrl);

		// Digital I/O mode
		unique case (dio.out_sel)
			ppsc_pkg::OSEL_END_FRAME: out_event = frame_end_i;
			ppsc_pkg::OSEL_FIRST_SYNC: out_event = first_sync_pulse_i;
			ppsc_pkg::OSEL_SECOND_SYNC: out_event = second_sync_pulse_i;
			default: out_event = 1'b0;
		endcase
		if (dio.valid_is_wd) begin
			out_event = watchdog_trigger_pulse_i;
		end
		next_state.latch_q = latch_in_i;
		unique case (dio.in_sel)
			ppsc_pkg::ISEL_START_FRAME: in_event = frame_start_i;
			ppsc_pkg::ISEL_LATCH_EDGE: in_event = latch_in_i && !state.latch_q;
			ppsc_pkg::ISEL_FIRST_SYNC: in_event = first_sync_pulse_i;
			ppsc_pkg::ISEL_SECOND_SYNC: in_event = second_sync_pulse_i;
		endcase
		next_state.valid = 1'b0;
		if (state.dmode) begin
			if (in_event) begin
				next_state.in_reg = io_pin_i;
			end
			if (watchdog_expired_i) begin
				next_state.wd_pending = 1'b1;
			end
			if (out_event) begin
				next_state.out_reg = out_data_i;
				next_state.valid = 1'b1;
			end
			// Expiry clears outputs now or defers to the output event
			if (watchdog_expired_i && !dio.wd_deferred) begin
				next_state.out_reg = '0;
				next_state.wd_pending = 1'b0;
			end else if (state.wd_pending && out_event) begin
				next_state.out_reg = '0;
				next_state.wd_pending = 1'b0;
			end
		end else begin
			next_state.wd_pending = 1'b0;
		end
		// Strobe pin level carries its polarity so the port comes from a flop
		next_state.valid = next_state.valid ^ dio.valid_low;
		// Bidirectional mode never drives; per-pin direction must be input there
		next_state.oe_n = (state.dmode && !dio.bidir) ? ~pin_dir_out_i : '1;

		// Host-bus modes
		cs_active = hbc.cs_high ? hb_cs_i : ~hb_cs_i;
		if (hbc.dir_enable) begin
			wr_act = cs_active && (hbc.wr_high ? hb_wr_i : ~hb_wr_i);
			rd_act = wr_act && (hbc.rd_high ? ~hb_rd_i : hb_rd_i);
			wr_act = wr_act && !rd_act;
		end else begin
			rd_act = cs_active && (hbc.rd_high ? hb_rd_i : ~hb_rd_i);
			wr_act = cs_active && (hbc.wr_high ? hb_wr_i : ~hb_wr_i);
		end
		next_state.hb_read = state.hmode && rd_act;
		next_state.hb_write = state.hmode && wr_act;

		// Sync mapping into event request bits; latch inputs seen when not sync
		next_state.evreq[0] = state.sync_cfg.first_map && first_sync_pulse_i;
		next_state.evreq[1] = state.sync_cfg.second_map && second_sync_pulse_i;
		next_state.latch_seen[0] = !state.sync_cfg.first_is_sync && first_latch_input_i;
		next_state.latch_seen[1] = !state.sync_cfg.second_is_sync && second_latch_input_i;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state <= '0;
			state.oe_n <= '1;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	ppsc_sync_pin u_first_sync (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.enable_i (state.sync_cfg.first_is_sync),
		.drv_i    (state.sync_cfg.first_drv),
		.pulse_i  (first_sync_pulse_i),
		.pin_o    (first_pin)
	);

	ppsc_sync_pin u_second_sync (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.enable_i (state.sync_cfg.second_is_sync),
		.drv_i    (state.sync_cfg.second_drv),
		.pulse_i  (second_sync_pulse_i),
		.pin_o    (second_pin)
	);

	ppsc_addr_latch #(.ADDR_W(ADDR_W)) u_ale_hi (
		.mclk_i         (mclk_i),
		.rst_n_i        (rst_n_i),
		.ale_high_pol_i (hbc.ale_high),
		.cs_qual_i      (hbc.ale_cs_qual),
		.cs_active_i    (cs_active),
		.strobe_i       (addr_latch_strobe_high_i),
		.addr_i         (hb_addr_i),
		.addr_o         (hb_addr_hi_o)
	);

	ppsc_addr_latch #(.ADDR_W(ADDR_W)) u_ale_lo (
		.mclk_i         (mclk_i),
		.rst_n_i        (rst_n_i),
		.ale_high_pol_i (hbc.ale_high),
		.cs_qual_i      (hbc.ale_cs_qual),
		.cs_active_i    (cs_active),
		.strobe_i       (addr_latch_strobe_low_i),
		.addr_i         (hb_addr_i),
		.addr_o         (hb_addr_lo_o)
	);

	////////////////////////////////////////////////////////////////////////////
	assign io_pin_o = state.out_reg;
	assign io_pin_oe_n_o = state.oe_n;
	assign reg_rdata_o = state.rdata;
	assign in_data_o = state.in_reg;
	assign output_valid_strobe_o = state.valid;
	assign first_sync_out_o = first_pin.out;
	assign first_sync_oe_n_o = first_pin.oe_n;
	assign second_sync_out_o = second_pin.out;
	assign second_sync_oe_n_o = second_pin.oe_n;
	assign first_latch_o = state.latch_seen;
	assign event_request_o = state.evreq;
	assign digital_mode_o = state.dmode;
	assign host_bus_mode_o = state.hmode;
	assign hb_read_o = state.hb_read;
	assign hb_write_o = state.hb_write;
endmodule
`default_nettype wire

// [test/ppsc_assertions.sv]
// Checker for the process-port configuration block.
// Assumes a bind into ppsc_top; mirrors the loader to predict fields.
`timescale 1ns/1ps
`default_nettype none
module ppsc_assertions (
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic        load_i,
	input wire logic [7:0]  load_iface_ctrl_i,
	input wire logic [7:0]  load_host_port_cfg_i,
	input wire logic [7:0]  load_sync_latch_cfg_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        first_sync_pulse_i,
	input wire logic        second_sync_pulse_i,
	input wire logic        first_sync_out_o,
	input wire logic        first_sync_oe_n_o,
	input wire logic [1:0]  event_request_o,
	input wire logic        digital_mode_o,
	input wire logic        host_bus_mode_o,
	input wire logic        hb_cs_i,
	input wire logic        hb_rd_i,
	input wire logic        hb_wr_i,
	input wire logic        hb_read_o,
	input wire logic        hb_write_o
);
	////////////////////////////////////////
	logic [7:0] ic, hp, sl;
	logic [1:0] st;
	// Outputs may lag a load, so judge only after two quiet cycles
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			{ic, hp, sl} <= 24'h000000;
			st <= 2'h0;
		end else begin
			if (load_i) begin
				{ic, hp, sl} <= {load_iface_ctrl_i, load_host_port_cfg_i, load_sync_latch_cfg_i};
			end
			st <= {st[0], !load_i};
		end
	end
	wire logic hb_code = ic >= ppsc_pkg::MODE_HBUS_FIRST && ic <= ppsc_pkg::MODE_HBUS_LAST;
	wire logic ok = st == 2'h3 && !load_i;
	wire logic hbm = ok && hb_code;
	wire logic cs_on = hb_cs_i == hp[5];
	wire logic rd_on = cs_on && !hp[6] && hb_rd_i == hp[4];
	wire logic wr_on = cs_on && !hp[6] && hb_wr_i == hp[3];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	chk_read_host: assert property (reg_rd_i && reg_addr_i == ppsc_pkg::ADDR_HOST_PORT_CFG
		|=> reg_rdata_o == $past(hp)) else $error("host config read wrong");
	chk_read_sync: assert property (reg_rd_i && reg_addr_i == ppsc_pkg::ADDR_SYNC_LATCH_CFG
		|=> reg_rdata_o == $past(sl)) else $error("sync config read wrong");
	chk_mode_decode: assert property (ok |-> digital_mode_o == (ic == ppsc_pkg::MODE_DIGITAL_IO)
		&& host_bus_mode_o == hb_code) else $error("mode decode wrong");
	chk_map_first_off: assert property (ok && !sl[3] |-> !event_request_o[0])
		else $error("first sync event while unmapped");
	chk_map_first_on: assert property (ok && sl[3] && first_sync_pulse_i
		|-> ##[0:2] event_request_o[0]) else $error("first sync event missing");
	chk_map_second_off: assert property (ok && !sl[7] |-> !event_request_o[1])
		else $error("second sync event while unmapped");
	chk_map_second_on: assert property (ok && sl[7] && second_sync_pulse_i
		|-> ##[0:2] event_request_o[1]) else $error("second sync event missing");
	chk_drive_pushpull: assert property (ok && sl[2] && !sl[0] |-> !first_sync_oe_n_o)
		else $error("push-pull pin released");
	chk_drive_level: assert property (ok && sl[2] && sl[0] && !first_sync_oe_n_o
		|-> first_sync_out_o == sl[1]) else $error("single-ended pin drives wrong level");
	chk_read_strobe: assert property ((hbm && rd_on)[*3] |-> hb_read_o)
		else $error("host read not seen");
	chk_write_strobe: assert property ((hbm && wr_on)[*3] |-> hb_write_o)
		else $error("host write not seen");
	chk_cs_gate: assert property ((hbm && !cs_on)[*3] |-> !hb_read_o && !hb_write_o)
		else $error("access without chip select");
	cover property (hbm && rd_on);
	cover property (hbm && wr_on);
	cover property (ok && sl[3] && first_sync_pulse_i);
endmodule
`default_nettype wire

// [test/ppsc_host_model.sv]
// Host processor model on the parallel host bus.
// Assumes cfg_i holds the host port config; one access per go_i pulse.
`timescale 1ns/1ps
`default_nettype none
module ppsc_host_model (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  cfg_i,
	input  wire logic        go_i,
	input  wire logic        write_i,
	input  wire logic        hi_i,
	input  wire logic [15:0] addr_i,
	output logic             hb_cs_o,
	output logic             hb_rd_o,
	output logic             hb_wr_o,
	output logic             ale_hi_o,
	output logic             ale_lo_o,
	output logic [15:0]      hb_addr_o
);
	////////////////////////////////////////
	logic [3:0] ph;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || ph == 4'h9) ph <= 4'h0;
		else if (go_i) ph <= 4'h1;
		else if (ph != 4'h0) ph <= ph + 4'h1;
	end
	wire logic lat = ph == 4'h1 || ph == 4'h2;
	wire logic acc = ph >= 4'h4 && ph <= 4'h7;
	// Active level is on ~^ polarity; idle shows the inverse
	always_comb begin
		hb_cs_o = (ph != 4'h0) ~^ cfg_i[5];
		hb_rd_o = cfg_i[6] ? write_i ~^ cfg_i[4] : (acc && !write_i) ~^ cfg_i[4];
		hb_wr_o = cfg_i[6] ? acc ~^ cfg_i[3] : (acc && write_i) ~^ cfg_i[3];
		ale_hi_o = (lat && hi_i) ~^ cfg_i[2];
		ale_lo_o = (lat && !hi_i) ~^ cfg_i[2];
		// Address held past the strobe end, then driven inverted
		hb_addr_o = (ph >= 4'h1 && ph <= 4'h5) ? addr_i : ~addr_i;
	end
endmodule
`default_nettype wire

// [test/ppsc_top_tb.sv]
// Self-checking bench for the process-port configuration block.
// Assumes the package, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ppsc_top_tb;
	logic        mclk_i, rst_n_i, load_i, reg_wr_i, reg_rd_i, go, wr_op, hi;
	logic [7:0]  load_iface_ctrl_i, load_host_port_cfg_i, load_sync_latch_cfg_i, reg_wdata_i;
	logic [7:0]  reg_rdata_o, ic_v;
	logic [11:0] reg_addr_i;
	logic        frame_start_i, frame_end_i, first_sync_pulse_i, second_sync_pulse_i;
	logic        first_latch_input_i, second_latch_input_i, latch_in_i;
	logic        watchdog_trigger_pulse_i, watchdog_expired_i;
	logic [15:0] out_data_i, pin_dir_out_i, io_pin_i, op_addr, rnd, bg, pd;
	logic [15:0] io_pin_o, io_pin_oe_n_o, in_data_o, hb_addr_hi_o, hb_addr_lo_o;
	logic        output_valid_strobe_o, first_sync_out_o, first_sync_oe_n_o, seen_rd, seen_wr;
	logic        second_sync_out_o, second_sync_oe_n_o, digital_mode_o, host_bus_mode_o;
	logic        hb_read_o, hb_write_o;
	logic [1:0]  first_latch_o, event_request_o, ev;
	wire logic   hb_cs_i, hb_rd_i, hb_wr_i, addr_latch_strobe_high_i, addr_latch_strobe_low_i;
	wire logic [15:0] hb_addr_i;
	int          failures = 0;
	int          compares = 0;
	////////////////////////////////////////
	ppsc_top DUT (.*);
	ppsc_host_model host (.mclk_i, .rst_n_i, .cfg_i(load_host_port_cfg_i), .go_i(go),
		.write_i(wr_op), .hi_i(hi), .addr_i(op_addr), .hb_cs_o(hb_cs_i), .hb_rd_o(hb_rd_i),
		.hb_wr_o(hb_wr_i), .ale_hi_o(addr_latch_strobe_high_i),
		.ale_lo_o(addr_latch_strobe_low_i), .hb_addr_o(hb_addr_i));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// Background inputs still toggle so their logic is exercised
	always @(posedge mclk_i) begin
		bg <= lfsr(bg);
		{frame_start_i, frame_end_i, first_latch_input_i, second_latch_input_i} <= bg[3:0];
		{latch_in_i, watchdog_trigger_pulse_i, watchdog_expired_i} <= bg[6:4];
		out_data_i <= bg;
		pin_dir_out_i <= ~bg;
		io_pin_i <= {bg[7:0], bg[15:8]};
	end
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic expect_reg(input logic [11:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 check_val(16'(reg_rdata_o), 16'(e));
	endtask
	task automatic load(input logic [7:0] ic, hp, sl);
		@(posedge mclk_i);
		load_i <= 1'b1;
		{load_iface_ctrl_i, load_host_port_cfg_i, load_sync_latch_cfg_i} <= {ic, hp, sl};
		@(posedge mclk_i);
		load_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic conclude;
		$display("Counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge mclk_i);
		failures++;
		conclude();
	end
	initial begin
		bg = 16'h0019;
		rnd = 16'h0019;
		{rst_n_i, load_i, reg_wr_i, reg_rd_i, go, wr_op, hi} <= 7'h00;
		{load_iface_ctrl_i, load_host_port_cfg_i, load_sync_latch_cfg_i} <= 24'h000000;
		{reg_addr_i, reg_wdata_i, op_addr} <= 36'h000000000;
		{first_sync_pulse_i, second_sync_pulse_i} <= 2'h0;
		{frame_start_i, frame_end_i, first_latch_input_i, second_latch_input_i} <= 4'h0;
		{latch_in_i, watchdog_trigger_pulse_i, watchdog_expired_i} <= 3'h0;
		{out_data_i, pin_dir_out_i, io_pin_i} <= 48'h000000000000;
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		expect_reg(ppsc_pkg::ADDR_HOST_PORT_CFG, 8'h00);
		expect_reg(ppsc_pkg::ADDR_SYNC_LATCH_CFG, 8'h00);
		expect_reg(ppsc_pkg::ADDR_IFACE_CTRL, 8'h00);
		expect_reg(12'h152, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			ic_v = (i % 7 == 0) ? ppsc_pkg::MODE_DIGITAL_IO : ppsc_pkg::MODE_HBUS_FIRST + 8'(i % 6);
			load(ic_v, rnd[7:0], rnd[15:8]);
			reg_write(ppsc_pkg::ADDR_HOST_PORT_CFG, ~rnd[7:0]);
			reg_write(ppsc_pkg::ADDR_SYNC_LATCH_CFG, ~rnd[15:8]);
			expect_reg(ppsc_pkg::ADDR_HOST_PORT_CFG, rnd[7:0]);
			expect_reg(ppsc_pkg::ADDR_SYNC_LATCH_CFG, rnd[15:8]);
			expect_reg(ppsc_pkg::ADDR_IFACE_CTRL, ic_v);
			check_val(16'(digital_mode_o), 16'(ic_v == ppsc_pkg::MODE_DIGITAL_IO));
			check_val(16'(host_bus_mode_o), 16'(ic_v != ppsc_pkg::MODE_DIGITAL_IO));
		end
		$display("test loads and ignored writes done");
		for (int m = 0; m < 2; m++) begin
			for (int d = 0; d < 4; d++) begin
				load(ppsc_pkg::MODE_DIGITAL_IO, 8'h00, {m[0], 1'b1, d[1:0], m[0], 1'b1, d[1:0]});
				check_val(16'(first_sync_oe_n_o), 16'(d[0]));
				check_val(16'(second_sync_oe_n_o), 16'(d[0]));
				if (!d[0]) check_val(16'(first_sync_out_o), 16'(!d[1]));
				ev = 2'h0;
				@(posedge mclk_i);
				{first_sync_pulse_i, second_sync_pulse_i} <= 2'h3;
				for (int k = 0; k < 5; k++) begin
					#1 ev = ev | event_request_o;
					@(posedge mclk_i);
					{first_sync_pulse_i, second_sync_pulse_i} <= 2'h0;
				end
				check_val(16'(ev), 16'({m[0], m[0]}));
			end
		end
		$display("test sync pins and event map done");
		for (int v = 0; v < 2; v++) begin
			load(ppsc_pkg::MODE_DIGITAL_IO, {2'h1, 2'h0, 1'b0, v[0], 1'b0, v[0]}, 8'h00);
			#1 pd = pin_dir_out_i;
			@(posedge mclk_i);
			#1 check_val(io_pin_oe_n_o, v[0] ? 16'hffff : ~pd);
			check_val(16'(output_valid_strobe_o), 16'(v[0]));
		end
		$display("test digital direction and strobe done");
		for (int c = 0; c < 32; c++) begin
			rnd = lfsr(rnd);
			load(ppsc_pkg::MODE_HBUS_FIRST + 8'(c % 6), {rnd[0], c[3:0], rnd[1], 2'h0}, 8'h00);
			op_addr <= rnd;
			wr_op <= c[4];
			hi <= rnd[2];
			{seen_rd, seen_wr} = 2'h0;
			@(posedge mclk_i);
			go <= 1'b1;
			@(posedge mclk_i);
			go <= 1'b0;
			repeat (11) begin
				#1 {seen_rd, seen_wr} = {seen_rd | hb_read_o, seen_wr | hb_write_o};
				@(posedge mclk_i);
			end
			check_val(16'(seen_rd), 16'(!c[4]));
			check_val(16'(seen_wr), 16'(c[4]));
			check_val(rnd[2] ? hb_addr_hi_o : hb_addr_lo_o, rnd);
		end
		$display("test host bus strobes done");
		conclude();
	end
endmodule
bind ppsc_top ppsc_assertions chk (.*);
`default_nettype wire
